// file: core/core_mode_sticky_status_regs.sv
// How it works
// - mode a bits 0,1 enable bit reversal
// - mode a bits 2-7,10 pick alternate sets
// - mode a bit 11 permits interrupt nesting
// - mode a bit 12 is global interrupt enable
// - mode a bit 13 saturates alu results
// - bit 14 sign extends, exchange writes excluded
// - bit 15 picks truncate over round nearest
// - bit 16 picks 32 over 40 bit rounding
// - bus master condition only when field zero
// - mode b bits 25-31 read-only id, revision
// - mode b bits 0-2 pick edge sensitivity
// - bit 4 disables cache, bit 19 freezes
// - mode b bits 5,11 run timers
// - bits 7,12 choose counting or generation mode
// - bits 3,10 choose width or period capture
// - bits 9,14 choose leading edge polarity
// - bits 8,13 route timer interrupt priority
// - bits 15-18 set flag pin directions
// - mode b bit 6 locks external bus
// - reset loads sticky status initial value
// - sticky bits hold; stack full, empty bits live; stack bits unwritable
// - timer, buffer, stack exceptions set sticky bits
// - effect one cycle late, reads see new
// - reset clears mode register a
// - immediate mask set, clear, toggle, test
`default_nettype none
module core_mode_sticky_status_regs
  import core_regs_pkg::*;
#(
  parameter logic [4:0] PROC_ID = 5'h05,   // arbitrary identity value
  parameter logic [1:0] PROC_REV = 2'h0    // arbitrary revision value
)
(
  input wire logic i_clk,                  // core clock, 250 MHz
  input wire logic i_rst_n,                // async reset, active low
  input wire logic i_op_en,                // register instruction valid
  input wire bit_op_t i_op,                // move or bit operation
  input wire reg_sel_t i_op_sel,           // target register
  input wire logic [31:0] i_op_data,       // move data or immediate mask
  input wire logic i_rd_en,                // read request
  input wire reg_sel_t i_rd_sel,           // register to read
  input wire logic i_px_write,             // exchange register write in progress
  input wire logic i_bus_owned,            // this core holds the shared bus
  input wire logic [1:0] i_timer_irq,      // timer interrupt pulses
  input wire logic [31:0] i_sticky_evt,    // exception event pulses
  input wire logic i_pc_stack_full,        // live pc stack full
  input wire logic i_pc_stack_empty,       // live pc stack empty
  input wire logic i_status_stack_empty,   // live status stack empty
  input wire logic i_loop_stack_empty,     // live loop stack empty
  output logic [31:0] o_rd_data,           // read data
  output logic o_rd_valid,                 // read data valid pulse
  output logic o_bit_test_flag,            // test or compare outcome
  output logic o_bit_test_valid,           // outcome valid pulse
  output logic o_bitrev_gen_two_en,        // bit reversal, generator two
  output logic o_bitrev_gen_one_en,        // bit reversal, generator one
  output logic o_alt_compute_select,       // alternate compute set
  output logic o_alt_gen_one_upper,        // alternate generator one upper
  output logic o_alt_gen_one_lower,        // alternate generator one lower
  output logic o_alt_gen_two_upper,        // alternate generator two upper
  output logic o_alt_gen_two_lower,        // alternate generator two lower
  output logic o_alt_regfile_upper,        // alternate register file upper
  output logic o_alt_regfile_lower,        // alternate register file lower
  output logic o_irq_nesting_en,           // nesting allowed
  output logic o_global_irq_en,            // interrupts allowed
  output logic o_alu_saturate_en,          // saturate fixed-point results
  output logic o_short_sign_extend_en,     // sign extension applied now
  output logic o_round_chop_select,        // 1 truncate
  output logic o_round_length_select,      // 1 round to 32 bits
  output logic o_bus_master_cond,          // bus master condition value
  output logic [2:0] o_irq_edge_sel,       // irq pin sensitivity
  output logic o_icache_off,               // cache disabled
  output logic o_icache_hold,              // cache frozen
  output logic o_ext_bus_hold,             // external bus locked
  output logic [1:0] o_timer_run,          // timer enables
  output logic [1:0] o_timer_mode_sel,     // 1 width generation
  output logic [1:0] o_timer_period_capture, // 1 period capture
  output logic [1:0] o_timer_edge_sel,     // 1 high to low
  output logic [1:0] o_timer_prio_route,   // 1 high priority
  output logic o_timer_high_prio_irq,      // latch pulse for high priority slot
  output logic o_timer_low_prio_irq,       // latch pulse for low priority slot
  output logic [3:0] o_flag_dir,           // flag pin directions
  output logic [31:0] o_sticky_status      // sticky status contents
);
  typedef struct packed {
    logic [31:0] mode_a;
    logic [19:0] mode_b;
    logic [31:0] eff_a;
    logic [19:0] eff_b;
    logic bm_cond;
    logic sext;
    logic hi_irq;
    logic lo_irq;
    logic [31:0] rd_data;
    logic rd_valid;
    logic btf;
    logic btf_valid;
  } regs_st_t;

  regs_st_t st_r;
  regs_st_t st_nxt;

  logic [31:0] mode_b_full;
  logic [31:0] sticky_val;
  logic [31:0] cur_val;
  logic [31:0] new_val;
  logic test_val;
  logic sticky_wr;
  logic is_store;

  function automatic logic [31:0] pick_reg(input reg_sel_t sel, input logic [31:0] a,
                                           input logic [31:0] b, input logic [31:0] s);
    case (sel)
      SEL_MODE_A: pick_reg = a;
      SEL_MODE_B: pick_reg = b;
      SEL_STICKY: pick_reg = s;
      default: pick_reg = 32'h0000_0000;
    endcase
  endfunction : pick_reg

  // identity and revision are fixed wiring, never stored
  assign mode_b_full = {PROC_ID[4:3], PROC_REV, PROC_ID[2:0], 5'h00, st_r.mode_b};
  assign cur_val = pick_reg(i_op_sel, st_r.mode_a, mode_b_full, sticky_val);
  assign is_store = i_op_en && (i_op != OP_TST) && (i_op != OP_XOR);
  assign sticky_wr = is_store && (i_op_sel == SEL_STICKY);

  bit_manip_unit u_bit_manip (
    .i_op (i_op),
    .i_cur (cur_val),
    .i_mask (i_op_data),
    .o_new (new_val),
    .o_test (test_val)
  );

  sticky_status_unit u_sticky (
    .i_clk (i_clk),
    .i_rst_n (i_rst_n),
    .i_wr (sticky_wr),
    .i_wr_data (new_val),
    .i_evt (i_sticky_evt),
    .i_live ({i_loop_stack_empty, i_status_stack_empty, i_pc_stack_empty, i_pc_stack_full}),
    .o_value (sticky_val)
  );

  always_comb
  begin
    st_nxt = st_r;
    if (is_store && (i_op_sel == SEL_MODE_A))
    begin
      st_nxt.mode_a = new_val & A_WR_MASK;
    end
    if (is_store && (i_op_sel == SEL_MODE_B))
    begin
      st_nxt.mode_b = new_val[19:0];
    end
    // the logic sees the previous store one cycle after the register itself
    st_nxt.eff_a = st_r.mode_a;
    st_nxt.eff_b = st_r.mode_b;
    st_nxt.bm_cond = (st_r.mode_a[A_COND_CODE_SELECT_HI:A_COND_CODE_SELECT_LO] == 2'h0) && i_bus_owned;
    st_nxt.sext = st_r.mode_a[A_SEXT] && !i_px_write;
    st_nxt.hi_irq = |(i_timer_irq & {st_r.eff_b[B_T1_PRIO], st_r.eff_b[B_T0_PRIO]});
    st_nxt.lo_irq = |(i_timer_irq & ~{st_r.eff_b[B_T1_PRIO], st_r.eff_b[B_T0_PRIO]});
    // reads see registers directly, so a store is visible on the next read
    st_nxt.rd_valid = i_rd_en;
    if (i_rd_en)
    begin
      st_nxt.rd_data = pick_reg(i_rd_sel, st_r.mode_a, mode_b_full, sticky_val);
    end
    st_nxt.btf_valid = i_op_en && ((i_op == OP_TST) || (i_op == OP_XOR));
    if (st_nxt.btf_valid)
    begin
      st_nxt.btf = test_val;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r.mode_a <= A_RESET;
      st_r.mode_b <= B_RESET[19:0];
      st_r.eff_a <= A_RESET;
      st_r.eff_b <= B_RESET[19:0];
      st_r.bm_cond <= 1'b0;
      st_r.sext <= 1'b0;
      st_r.hi_irq <= 1'b0;
      st_r.lo_irq <= 1'b0;
      st_r.rd_data <= 32'h0000_0000;
      st_r.rd_valid <= 1'b0;
      st_r.btf <= 1'b0;
      st_r.btf_valid <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_rd_data = st_r.rd_data;
  assign o_rd_valid = st_r.rd_valid;
  assign o_bit_test_flag = st_r.btf;
  assign o_bit_test_valid = st_r.btf_valid;
  assign o_sticky_status = sticky_val;

  assign o_bitrev_gen_two_en = st_r.eff_a[A_BITREV_TWO];
  assign o_bitrev_gen_one_en = st_r.eff_a[A_BITREV_ONE];
  assign o_alt_compute_select = st_r.eff_a[A_ALT_LO];
  assign o_alt_gen_one_upper = st_r.eff_a[A_ALT_LO + 1];
  assign o_alt_gen_one_lower = st_r.eff_a[A_ALT_LO + 2];
  assign o_alt_gen_two_upper = st_r.eff_a[A_ALT_LO + 3];
  assign o_alt_gen_two_lower = st_r.eff_a[A_ALT_LO + 4];
  assign o_alt_regfile_upper = st_r.eff_a[A_ALT_HI];
  assign o_alt_regfile_lower = st_r.eff_a[A_ALT_RF_LOWER];
  assign o_irq_nesting_en = st_r.eff_a[A_NEST];
  assign o_global_irq_en = st_r.eff_a[A_GIE];
  assign o_alu_saturate_en = st_r.eff_a[A_SAT];
  assign o_short_sign_extend_en = st_r.sext;
  assign o_round_chop_select = st_r.eff_a[A_CHOP];
  assign o_round_length_select = st_r.eff_a[A_RLEN];
  assign o_bus_master_cond = st_r.bm_cond;

  assign o_irq_edge_sel = st_r.eff_b[B_IRQ_EDGE_HI:B_IRQ_EDGE_LO];
  assign o_icache_off = st_r.eff_b[B_ICACHE_OFF];
  assign o_icache_hold = st_r.eff_b[B_ICACHE_HOLD];
  assign o_ext_bus_hold = st_r.eff_b[B_BUS_HOLD];
  assign o_timer_run = {st_r.eff_b[B_T1_RUN], st_r.eff_b[B_T0_RUN]};
  assign o_timer_mode_sel = {st_r.eff_b[B_T1_MODE], st_r.eff_b[B_T0_MODE]};
  assign o_timer_period_capture = {st_r.eff_b[B_T1_PERIOD], st_r.eff_b[B_T0_PERIOD]};
  assign o_timer_edge_sel = {st_r.eff_b[B_T1_EDGE], st_r.eff_b[B_T0_EDGE]};
  assign o_timer_prio_route = {st_r.eff_b[B_T1_PRIO], st_r.eff_b[B_T0_PRIO]};
  assign o_timer_high_prio_irq = st_r.hi_irq;
  assign o_timer_low_prio_irq = st_r.lo_irq;
  assign o_flag_dir = st_r.eff_b[B_FLAG_DIR_HI:B_FLAG_DIR_LO];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  gie_effect_lag_a: assert property (
    (i_op_en && i_op == OP_WRITE && i_op_sel == SEL_MODE_A) |-> ##2 o_global_irq_en == $past(i_op_data[12], 2))
    else $error("global enable not applied two cycles after the move");
  rlen_hold_a: assert property (
    (i_op_en && i_op == OP_WRITE && i_op_sel == SEL_MODE_A) |=> o_round_length_select == $past(st_r.mode_a[A_RLEN]))
    else $error("rounding length changed without effect latency");
  read_after_write_a: assert property (
    (i_op_en && i_op == OP_WRITE && i_op_sel == SEL_MODE_A) ##1 (i_rd_en && i_rd_sel == SEL_MODE_A)
    |=> o_rd_valid && o_rd_data == ($past(i_op_data, 2) & A_WR_MASK))
    else $error("read after move does not return the new value");
  bus_cond_a: assert property (
    o_bus_master_cond |-> $past(i_bus_owned) && ($past(st_r.mode_a[A_COND_CODE_SELECT_HI:A_COND_CODE_SELECT_LO]) == 2'h0))
    else $error("bus master condition without bus ownership");
  id_readonly_a: assert property (
    (i_rd_en && i_rd_sel == SEL_MODE_B) |=> o_rd_data[31:25] == {PROC_ID[4:3], PROC_REV, PROC_ID[2:0]})
    else $error("identity field altered");
  flag_dir_a: assert property (
    (i_op_en && i_op == OP_SET && i_op_sel == SEL_MODE_B && i_op_data[15]) |-> ##2 o_flag_dir[0])
    else $error("flag direction not set by bit set");
  hi_route_a: assert property (
    (i_timer_irq == 2'h1 && o_timer_prio_route[0]) |=> o_timer_high_prio_irq && !o_timer_low_prio_irq)
    else $error("timer interrupt routed to wrong slot");
  sext_px_a: assert property (
    i_px_write |=> !o_short_sign_extend_en)
    else $error("sign extension applied to exchange write");
  btf_zero_mask_a: assert property (
    (i_op_en && i_op == OP_TST && i_op_data == 32'h0000_0000) |=> o_bit_test_valid && o_bit_test_flag)
    else $error("empty-mask test did not report all set");
  unmapped_read_a: assert property (
    (i_rd_en && i_rd_sel == SEL_NONE) |=> o_rd_data == 32'h0000_0000)
    else $error("unmapped select did not read zero");
endmodule : core_mode_sticky_status_regs
`default_nettype wire

// file: core/core_regs_pkg.sv
`default_nettype none
package core_regs_pkg;
  // register select for instruction access
  typedef enum logic [1:0] {
    SEL_MODE_A = 2'h0,
    SEL_MODE_B = 2'h1,
    SEL_STICKY = 2'h2,
    SEL_NONE = 2'h3
  } reg_sel_t;

  // whole-register move and the immediate-mask bit operations
  typedef enum logic [2:0] {
    OP_WRITE = 3'h0,
    OP_SET = 3'h1,
    OP_CLR = 3'h2,
    OP_TGL = 3'h3,
    OP_TST = 3'h4,
    OP_XOR = 3'h5
  } bit_op_t;

  localparam int EFFECT_LATENCY = 1;

  // mode register a fields
  localparam int A_BITREV_TWO = 0;
  localparam int A_BITREV_ONE = 1;
  localparam int A_ALT_LO = 2;
  localparam int A_ALT_HI = 7;
  localparam int A_ALT_RF_LOWER = 10;
  localparam int A_NEST = 11;
  localparam int A_GIE = 12;
  localparam int A_SAT = 13;
  localparam int A_SEXT = 14;
  localparam int A_CHOP = 15;
  localparam int A_RLEN = 16;
  localparam int A_COND_CODE_SELECT_LO = 17;
  localparam int A_COND_CODE_SELECT_HI = 18;
  localparam logic [31:0] A_RESET = 32'h0000_0000;
  localparam logic [31:0] A_WR_MASK = 32'h0007_fcff;

  // mode register b fields
  localparam int B_IRQ_EDGE_LO = 0;
  localparam int B_IRQ_EDGE_HI = 2;
  localparam int B_T0_PERIOD = 3;
  localparam int B_ICACHE_OFF = 4;
  localparam int B_T0_RUN = 5;
  localparam int B_BUS_HOLD = 6;
  localparam int B_T0_MODE = 7;
  localparam int B_T0_PRIO = 8;
  localparam int B_T0_EDGE = 9;
  localparam int B_T1_PERIOD = 10;
  localparam int B_T1_RUN = 11;
  localparam int B_T1_MODE = 12;
  localparam int B_T1_PRIO = 13;
  localparam int B_T1_EDGE = 14;
  localparam int B_FLAG_DIR_LO = 15;
  localparam int B_FLAG_DIR_HI = 18;
  localparam int B_ICACHE_HOLD = 19;
  localparam logic [31:0] B_RESET = 32'h0000_0000;
  localparam logic [31:0] B_WR_MASK = 32'h000f_ffff;

  // sticky status fields
  localparam int S_T0_CAPTURED = 12;
  localparam int S_T0_EXPIRED = 13;
  localparam int S_T1_CAPTURED = 14;
  localparam int S_T1_EXPIRED = 15;
  localparam int S_CB_SEVEN = 17;
  localparam int S_CB_FIFTEEN = 18;
  localparam int S_PC_FULL = 21;
  localparam int S_PC_EMPTY = 22;
  localparam int S_SS_OVF = 23;
  localparam int S_SS_EMPTY = 24;
  localparam int S_LS_OVF = 25;
  localparam int S_LS_EMPTY = 26;
  localparam logic [31:0] S_RESET = 32'h0540_0000;
  localparam logic [31:0] S_STICKY_MASK = 32'h02a6_f3e7;
  localparam logic [31:0] S_WR_MASK = 32'h0006_f3e7;
endpackage : core_regs_pkg
`default_nettype wire

// file: core/bit_manip_unit.sv
`default_nettype none
module bit_manip_unit
  import core_regs_pkg::*;
(
  input wire bit_op_t i_op,          // operation
  input wire logic [31:0] i_cur,     // current register value
  input wire logic [31:0] i_mask,    // immediate mask or move data
  output logic [31:0] o_new,         // value to store
  output logic o_test                // test or compare outcome
);
  function automatic logic [31:0] apply_op(input bit_op_t op, input logic [31:0] cur, input logic [31:0] m);
    case (op)
      OP_WRITE: apply_op = m;
      OP_SET: apply_op = cur | m;
      OP_CLR: apply_op = cur & ~m;
      OP_TGL: apply_op = cur ^ m;
      default: apply_op = cur;
    endcase
  endfunction : apply_op

  always_comb
  begin
    o_new = apply_op(i_op, i_cur, i_mask);
    // test wants every masked bit set, compare wants the whole pattern equal
    if (i_op == OP_XOR)
    begin
      o_test = (i_cur == i_mask);
    end
    else
    begin
      o_test = ((i_cur & i_mask) == i_mask);
    end
  end
endmodule : bit_manip_unit
`default_nettype wire

// file: core/sticky_status_unit.sv
`default_nettype none
module sticky_status_unit
  import core_regs_pkg::*;
(
  input wire logic i_clk,               // core clock
  input wire logic i_rst_n,             // async reset, active low
  input wire logic i_wr,                // store request
  input wire logic [31:0] i_wr_data,    // value to store
  input wire logic [31:0] i_evt,        // exception event pulses
  input wire logic [3:0] i_live,        // pc full, pc empty, ss empty, ls empty
  output logic [31:0] o_value           // register contents
);
  typedef struct packed {
    logic [31:0] val;
  } sticky_st_t;

  sticky_st_t st_r;
  sticky_st_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (i_wr)
    begin
      st_nxt.val = (i_wr_data & S_WR_MASK) | (st_r.val & ~S_WR_MASK);
    end
    // events after the store so a clear in the same cycle cannot lose one
    st_nxt.val = (st_nxt.val | i_evt) & S_STICKY_MASK;
    st_nxt.val[S_PC_FULL] = i_live[0];
    st_nxt.val[S_PC_EMPTY] = i_live[1];
    st_nxt.val[S_SS_EMPTY] = i_live[2];
    st_nxt.val[S_LS_EMPTY] = i_live[3];
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_r.val <= S_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_value = st_r.val;

  sticky_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (st_r.val[S_CB_SEVEN] && !i_wr) |=> st_r.val[S_CB_SEVEN])
    else $error("sticky bit dropped without a store");
  live_track_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    1'b1 |=> st_r.val[S_PC_EMPTY] == $past(i_live[1]))
    else $error("pc empty bit does not follow its source");
  event_wins_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_evt[S_T0_EXPIRED] && i_wr && !i_wr_data[S_T0_EXPIRED]) |=> st_r.val[S_T0_EXPIRED])
    else $error("event lost against a clearing store");
endmodule : sticky_status_unit
`default_nettype wire

// file: tb/core_mode_sticky_status_regs_bench.sv
`default_nettype none
module core_mode_sticky_status_regs_bench
  import core_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [4:0] ID = 5'h0a; // arbitrary identity value
  localparam logic [1:0] REV = 2'h1; // arbitrary revision value
  localparam logic [31:0] IDB = {ID[4:3], REV, ID[2:0], 25'h0};
  localparam logic [31:0] STK = 32'h0286_f3e7;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_en = 1'b0;
  bit_op_t op = OP_WRITE;
  reg_sel_t op_sel = SEL_NONE;
  logic [31:0] op_data = 32'h0;
  logic rd_en = 1'b0;
  reg_sel_t rd_sel = SEL_NONE;
  logic px_write = 1'b0;
  logic bus_owned = 1'b0;
  logic [1:0] timer_irq = 2'h0;
  logic [31:0] sticky_evt = 32'h0;
  logic pc_full = 1'b0;
  logic pc_empty = 1'b1;
  logic ss_empty = 1'b1;
  logic ls_empty = 1'b1;
  logic [31:0] rd_data;
  logic [31:0] sticky;
  logic rd_valid, test_flag, test_valid, br8, bitrev_gen_one_en, cu, g1u, g1l, g2u, g2l, rfu, rfl, nest, gie, sat, sext;
  logic chop, rlen, bmc, ic_off, ic_hold, bus_hold, hi, lo;
  logic [2:0] irq_edge;
  logic [1:0] t_run, t_mode, t_per, t_edge, t_prio;
  logic [3:0] flag_dir;
  int error_cnt = 0;
  int comparisons = 0;
  logic [31:0] pats [4] = '{32'hffff_ffff, 32'h5555_5555, 32'haaaa_aaaa, 32'h0};
  bit_op_t tops [4] = '{OP_TST, OP_TST, OP_XOR, OP_XOR};
  logic [31:0] tmask [4] = '{32'h1004, 32'h1005, 32'h1004, 32'h1005};

  wire logic [31:0] a_fx = {15'h0, rlen, chop, sext, sat, gie, nest, rfl, 2'h0, rfu, g2l, g2u, g1l, g1u, cu, bitrev_gen_one_en, br8};
  wire logic [31:0] b_fx = {12'h0, ic_hold, flag_dir, t_edge[1], t_prio[1], t_mode[1], t_run[1], t_per[1],
                            t_edge[0], t_prio[0], t_mode[0], bus_hold, t_run[0], ic_off, t_per[0], irq_edge};

  core_mode_sticky_status_regs #(.PROC_ID(ID), .PROC_REV(REV)) core_mode_sticky_status_regs_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_op_en(op_en), .i_op(op), .i_op_sel(op_sel), .i_op_data(op_data),
    .i_rd_en(rd_en), .i_rd_sel(rd_sel), .i_px_write(px_write), .i_bus_owned(bus_owned),
    .i_timer_irq(timer_irq), .i_sticky_evt(sticky_evt), .i_pc_stack_full(pc_full),
    .i_pc_stack_empty(pc_empty), .i_status_stack_empty(ss_empty), .i_loop_stack_empty(ls_empty),
    .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_bit_test_flag(test_flag), .o_bit_test_valid(test_valid),
    .o_bitrev_gen_two_en(br8), .o_bitrev_gen_one_en(bitrev_gen_one_en), .o_alt_compute_select(cu),
    .o_alt_gen_one_upper(g1u), .o_alt_gen_one_lower(g1l), .o_alt_gen_two_upper(g2u),
    .o_alt_gen_two_lower(g2l), .o_alt_regfile_upper(rfu), .o_alt_regfile_lower(rfl),
    .o_irq_nesting_en(nest), .o_global_irq_en(gie), .o_alu_saturate_en(sat), .o_short_sign_extend_en(sext),
    .o_round_chop_select(chop), .o_round_length_select(rlen), .o_bus_master_cond(bmc),
    .o_irq_edge_sel(irq_edge), .o_icache_off(ic_off), .o_icache_hold(ic_hold), .o_ext_bus_hold(bus_hold),
    .o_timer_run(t_run), .o_timer_mode_sel(t_mode), .o_timer_period_capture(t_per),
    .o_timer_edge_sel(t_edge), .o_timer_prio_route(t_prio), .o_timer_high_prio_irq(hi),
    .o_timer_low_prio_irq(lo), .o_flag_dir(flag_dir), .o_sticky_status(sticky)
  );

  always #2 clk = ~clk;

  task automatic test_done;
    $display("comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got 0x%h expected 0x%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  // called at a falling edge; the instruction is taken at the next rising edge
  task automatic do_op(input bit_op_t o, input reg_sel_t s, input logic [31:0] d);
    op_en = 1'b1;
    op = o;
    op_sel = s;
    op_data = d;
    @(negedge clk);
    op_en = 1'b0;
  endtask : do_op

  task automatic rd_chk(input reg_sel_t s, input logic [31:0] exp);
    int n;
    rd_en = 1'b1;
    rd_sel = s;
    @(negedge clk);
    rd_en = 1'b0;
    n = 0;
    while (rd_valid !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    if (n == 4)
    begin
      error_cnt++;
      test_done();
    end
    chk(rd_data, exp);
    // one idle cycle so a following read never re-raises the strobe in this time step
    @(negedge clk);
  endtask : rd_chk

  // six cycles low, checks taken while reset is still applied
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    chk(sticky, S_RESET);
    chk(a_fx, 32'h0);
    chk(b_fx, 32'h0);
    rst_n = 1'b1;
    @(negedge clk);
  endtask : do_reset

  initial
  begin
    do_reset();
    rd_chk(SEL_MODE_A, 32'h0);
    rd_chk(SEL_MODE_B, IDB);
    rd_chk(SEL_STICKY, S_RESET);
    rd_chk(SEL_NONE, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      do_op(OP_WRITE, SEL_MODE_A, pats[i]);
      chk(a_fx, (i > 0) ? (pats[i - 1] & 32'h0001_fcff) : 32'h0);
      rd_chk(SEL_MODE_A, pats[i] & A_WR_MASK);
      chk(a_fx, pats[i] & 32'h0001_fcff);
      do_op(OP_WRITE, SEL_MODE_B, pats[i]);
      chk(b_fx, (i > 0) ? (pats[i - 1] & B_WR_MASK) : 32'h0);
      rd_chk(SEL_MODE_B, (pats[i] & B_WR_MASK) | IDB);
      chk(b_fx, pats[i] & B_WR_MASK);
    end
    bus_owned = 1'b1;
    for (int c = 3; c >= 0; c--)
    begin
      do_op(OP_WRITE, SEL_MODE_A, 32'(c) << 17);
      cyc(2);
      chk(bmc, c == 0);
    end
    bus_owned = 1'b0;
    cyc(2);
    chk(bmc, 32'h0);
    do_op(OP_WRITE, SEL_MODE_A, 32'h4000);
    cyc(1);
    chk(sext, 32'h1);
    px_write = 1'b1;
    cyc(2);
    chk(sext, 32'h0);
    px_write = 1'b0;
    cyc(2);
    chk(sext, 32'h1);
    do_op(OP_SET, SEL_MODE_A, 32'h1003);
    rd_chk(SEL_MODE_A, 32'h5003);
    do_op(OP_CLR, SEL_MODE_A, 32'h4001);
    rd_chk(SEL_MODE_A, 32'h1002);
    // toggling reserved bits 8 and 9 must leave them clear
    do_op(OP_TGL, SEL_MODE_A, 32'h0306);
    rd_chk(SEL_MODE_A, 32'h1004);
    for (int i = 0; i < 4; i++)
    begin
      do_op(tops[i], SEL_MODE_A, tmask[i]);
      chk(test_valid, 32'h1);
      chk(test_flag, (i % 2) == 0);
      cyc(1);
    end
    do_op(OP_WRITE, SEL_NONE, 32'hffff_ffff);
    rd_chk(SEL_MODE_A, 32'h1004);
    for (int r = 0; r < 4; r++)
    begin
      do_op(OP_WRITE, SEL_MODE_B, (32'(r[1]) << 13) | (32'(r[0]) << 8));
      cyc(1);
      for (int t = 1; t < 4; t++)
      begin
        timer_irq = 2'(t);
        @(negedge clk);
        chk(hi, (t & r) != 0);
        chk(lo, (t & ~r & 3) != 0);
      end
      timer_irq = 2'h0;
    end
    sticky_evt = 32'hffff_ffff;
    @(negedge clk);
    sticky_evt = 32'h0;
    chk(sticky, STK | S_RESET);
    cyc(3);
    chk(sticky, STK | S_RESET);
    pc_full = 1'b1;
    pc_empty = 1'b0;
    cyc(1);
    chk(sticky, STK | 32'h0520_0000);
    do_op(OP_WRITE, SEL_STICKY, 32'h0);
    chk(sticky, 32'h0280_0000 | 32'h0520_0000);
    cyc(1);
    // a fresh event wins over a clearing store in the same cycle
    sticky_evt = 32'h2000;
    do_op(OP_WRITE, SEL_STICKY, 32'h0);
    sticky_evt = 32'h0;
    chk(sticky, 32'h0280_2000 | 32'h0520_0000);
    cyc(1);
    do_op(OP_WRITE, SEL_STICKY, 32'hffff_ffff);
    chk(sticky, STK | 32'h0520_0000);
    rd_chk(SEL_STICKY, STK | 32'h0520_0000);
    pc_full = 1'b0;
    pc_empty = 1'b1;
    do_reset();
    rd_chk(SEL_MODE_A, 32'h0);
    rd_chk(SEL_MODE_B, IDB);
    chk(sticky, S_RESET);
    test_done();
  end
endmodule : core_mode_sticky_status_regs_bench
`default_nettype wire
